//--- design/rva_pkg.sv
// package for the reset and interrupt vector address generator
// assumes a 12-bit word program counter (8k bytes of program memory)
package rva_pkg;
   localparam int          RVA_PC_W       = 12;
   localparam int          RVA_NUM_SRC    = 25;
   localparam int          RVA_IDX_W      = 5;
   // table addresses, vector number n sits at n-1
   localparam logic [11:0] RVA_RESET_ADDR = 12'h000;
   localparam logic [11:0] RVA_EXT0_ADDR  = 12'h001;
   localparam logic [11:0] RVA_EXT1_ADDR  = 12'h002;
   localparam logic [11:0] RVA_PCG0_ADDR  = 12'h003;
   localparam logic [11:0] RVA_WDT_ADDR   = 12'h006;
   localparam logic [11:0] RVA_T2_ADDR    = 12'h007;
   localparam logic [11:0] RVA_T1_ADDR    = 12'h00a;
   localparam logic [11:0] RVA_T0_ADDR    = 12'h00e;
   localparam logic [11:0] RVA_SER_ADDR   = 12'h011;
   localparam logic [11:0] RVA_MISC_ADDR  = 12'h015;
   localparam logic [11:0] RVA_LAST_ADDR  = 12'h019;
   // fuse encoding: one means unprogrammed
   localparam logic        RVA_FUSE_UNPROG = 1'b1;
   localparam logic        RVA_FUSE_PROG   = 1'b0;
   // default boot reset address (2k byte boot section)
   localparam logic [11:0] RVA_BOOT_DFLT  = 12'hc00;

   typedef enum logic [1:0] {
      RVA_IDLE,
      RVA_RESET_LOAD,
      RVA_RUN
   } rva_state_t;
endpackage : rva_pkg

//--- design/rva_prio_enc.sv
// fixed priority encoder over the interrupt request lines
// assumes request bit 0 is the lowest vector number
`timescale 1ns/10ps
module rva_prio_enc
   import rva_pkg::*;
(
   // request side
   input  wire logic [RVA_NUM_SRC-1:0] req,
   // result
   output logic                        any,
   output logic [RVA_IDX_W-1:0]        idx
);
   // scan from the top so the lowest index is the last to win
   always_comb begin
      any = 1'b0;
      idx = '0;
      for (int i = RVA_NUM_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            idx = RVA_IDX_W'(i);
         end
      end
   end
endmodule : rva_prio_enc

//--- design/rva_vector_gen.sv
// reset and interrupt vector address generator
// assumes requests are already gated by their enables and are synchronous
// to clock; the core takes a vector on vec_valid and acknowledges it
//
// Overview of operation
// - every reset cause uses vector one, address zero while the fuse is unprogrammed
// - external requests zero and one at 0x001, 0x002
// - pin change groups 0x003-0x005, watchdog 0x006
// - timer two vectors at 0x007 to 0x009
// - timer one vectors at 0x00a to 0x00d
// - timer zero vectors at 0x00e to 0x010
// - serial vectors at 0x011 to 0x014
// - remaining vectors at 0x015 to 0x019
// - programmed fuse resets to boot reset address
// - select bit adds boot section start to vectors
// - table start 0x001 or boot address plus one
// - fuse one unprogrammed, zero programmed
//
// fuse and boot address are latched at the first edge after reset;
// the vector-table select bit stays live, as software moves it
// after reset release: one idle edge, then a one-cycle pc_load pulse
// carrying the reset target; dispatch starts on the edge after it
// an offer holds vec_valid, pc_addr and vec_source until the edge
// that samples vec_ack high, then one idle cycle before the next one
// no request is sampled while an offer stands; newer ones wait
// requests are levels; a source still raised after its ack is
// offered again, so the core must clear its flag in the handler
// limitation: relocated addresses wrap at the 12-bit program counter
`timescale 1ns/10ps
module rva_vector_gen
   import rva_pkg::*;
(
   // clock and reset
   input  wire logic                   clock,
   input  wire logic                   srst,
   // configuration
   input  wire logic                   boot_reset_select_fuse,
   input  wire logic                   vector_table_select,
   input  wire logic [RVA_PC_W-1:0]    boot_reset_addr,
   // peripheral request lines, bit 0 = vector 2
   input  wire logic                   ext_irq_zero,
   input  wire logic                   ext_irq_one,
   // pin change groups zero to two
   input  wire logic                   pin_change_irq_group0,
   input  wire logic                   pin_change_irq_group1,
   input  wire logic                   pin_change_irq_group2,
   // watchdog time-out
   input  wire logic                   watchdog_timeout_irq,
   // timer two: [0] compare a, [1] compare b, [2] overflow
   input  wire logic [2:0]             timer2_irq,
   // timer one: [0] capture, [1] compare a, [2] compare b, [3] overflow
   input  wire logic [3:0]             timer1_irq,
   // timer zero: [0] compare a, [1] compare b, [2] overflow
   input  wire logic [2:0]             timer0_irq,
   // serial transfer, receive and transmit
   input  wire logic                   spi_done_irq,
   input  wire logic                   rx_complete_irq,
   input  wire logic                   tx_buffer_empty_irq,
   input  wire logic                   tx_complete_irq,
   // conversion, memory, comparator, two-wire, store ready
   input  wire logic                   conversion_done_irq,
   input  wire logic                   nv_data_memory_ready_irq,
   input  wire logic                   comparator_irq,
   input  wire logic                   two_wire_serial_irq,
   input  wire logic                   self_program_store_ready_irq,
   // core side
   input  wire logic                   vec_ack,
   // reset load and vector offer, all registered
   output logic                        pc_load,
   output logic [RVA_PC_W-1:0]         pc_addr,
   output logic                        vec_valid,
   output logic [RVA_IDX_W-1:0]        vec_source
);
   logic [RVA_NUM_SRC-1:0] req;
   logic                   any_req;
   logic [RVA_IDX_W-1:0]   win_idx;
   logic [RVA_PC_W-1:0]    table_addr;
   logic [RVA_PC_W-1:0]    base_addr;
   logic [RVA_PC_W-1:0]    reset_target;

   rva_state_t             state_reg, state_next;
   logic                   pc_load_reg, pc_load_next;
   logic [RVA_PC_W-1:0]    pc_addr_reg, pc_addr_next;
   logic                   vec_valid_reg, vec_valid_next;
   logic [RVA_IDX_W-1:0]   vec_source_reg, vec_source_next;
   logic                   fuse_reg, fuse_next;
   logic [RVA_PC_W-1:0]    boot_addr_reg, boot_addr_next;

   // request vector ordered by table address, index 0 at 0x001;
   // this order is the whole priority scheme, keep it sorted
   assign req = {
      // 0x015 to 0x019
      self_program_store_ready_irq,
      two_wire_serial_irq,
      comparator_irq,
      nv_data_memory_ready_irq,
      conversion_done_irq,
      // 0x011 to 0x014
      tx_complete_irq,
      tx_buffer_empty_irq,
      rx_complete_irq,
      spi_done_irq,
      // 0x00e to 0x010
      timer0_irq,
      // 0x00a to 0x00d
      timer1_irq,
      // 0x007 to 0x009
      timer2_irq,
      // 0x003 to 0x006
      watchdog_timeout_irq,
      pin_change_irq_group2,
      pin_change_irq_group1,
      pin_change_irq_group0,
      // 0x001 and 0x002
      ext_irq_one,
      ext_irq_zero
   };

   // lowest index wins among simultaneous requests
   rva_prio_enc u_prio (
      .req (req),
      .any (any_req),
      .idx (win_idx)
   );

   // table address is index plus the first table entry
   assign table_addr = RVA_EXT0_ADDR + RVA_PC_W'(win_idx);
   // relocation base follows the select bit only, never the fuse
   assign base_addr = vector_table_select ? boot_addr_reg
                                          : RVA_RESET_ADDR;
   // reset target chosen by the latched fuse alone
   assign reset_target = (fuse_reg == RVA_FUSE_PROG)
                         ? boot_addr_reg
                         : RVA_RESET_ADDR;

   // fuse and boot address latched once per reset, at the idle edge;
   // a glitch on the fuse lines cannot then move the reset target
   always_comb begin
      fuse_next      = fuse_reg;
      boot_addr_next = boot_addr_reg;
      if (state_reg == RVA_IDLE) begin
         // idle lasts one edge, so this is a one-shot capture
         fuse_next      = boot_reset_select_fuse;
         boot_addr_next = boot_reset_addr;
      end
   end

   // configuration registers, reset to an unprogrammed fuse
   always_ff @(posedge clock) begin
      if (srst) begin
         fuse_reg      <= RVA_FUSE_UNPROG;
         boot_addr_reg <= RVA_BOOT_DFLT;
      end else begin
         fuse_reg      <= fuse_next;
         boot_addr_reg <= boot_addr_next;
      end
   end

   // sequencing: reset load once, then dispatch one vector at a time
   always_comb begin
      // hold by default; pc_load is a pulse, so it drops
      state_next      = state_reg;
      pc_load_next    = 1'b0;
      pc_addr_next    = pc_addr_reg;
      vec_valid_next  = vec_valid_reg;
      vec_source_next = vec_source_reg;
      case (state_reg)
         RVA_IDLE: begin
            // one edge to latch the configuration after release
            state_next = RVA_RESET_LOAD;
         end

         RVA_RESET_LOAD: begin
            // fuse sampled after reset release, never under reset
            pc_load_next = 1'b1;
            pc_addr_next = reset_target;
            state_next   = RVA_RUN;
         end

         RVA_RUN: begin
            // withdraw on the ack edge; no new offer in that cycle
            if (vec_valid_reg && vec_ack) begin
               vec_valid_next = 1'b0;
            end else if (!vec_valid_reg && any_req) begin
               // address frozen while offered so the core sees it stable
               vec_valid_next  = 1'b1;
               vec_source_next = win_idx;
               pc_addr_next    = base_addr + table_addr;
            end
         end

         default: begin
            // illegal encoding restarts the reset sequence
            state_next = RVA_IDLE;
         end
      endcase
   end

   // state and output registers
   always_ff @(posedge clock) begin
      if (srst) begin
         // every output idle, state back to the latch edge
         state_reg      <= RVA_IDLE;
         pc_load_reg    <= 1'b0;
         pc_addr_reg    <= RVA_RESET_ADDR;
         vec_valid_reg  <= 1'b0;
         vec_source_reg <= '0;
      end else begin
         state_reg      <= state_next;
         pc_load_reg    <= pc_load_next;
         pc_addr_reg    <= pc_addr_next;
         vec_valid_reg  <= vec_valid_next;
         vec_source_reg <= vec_source_next;
      end
   end

   // top outputs taken straight from the registers
   assign pc_load    = pc_load_reg;
   assign pc_addr    = pc_addr_reg;
   assign vec_valid  = vec_valid_reg;
   assign vec_source = vec_source_reg;
endmodule : rva_vector_gen

//--- tb/rva_vector_gen_sva.sv
// output checks for the vector generator
// assumes config inputs stay steady while a load or vector is shown
`timescale 1ns/10ps
module rva_vector_gen_sva
   import rva_pkg::*;
(
   // clock and reset
   input wire logic                 clock,
   input wire logic                 srst,
   // configuration
   input wire logic                 boot_reset_select_fuse,
   input wire logic                 vector_table_select,
   input wire logic [RVA_PC_W-1:0]  boot_reset_addr,
   // core side
   input wire logic                 vec_ack,
   input wire logic                 pc_load,
   input wire logic [RVA_PC_W-1:0]  pc_addr,
   input wire logic                 vec_valid,
   input wire logic [RVA_IDX_W-1:0] vec_source
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   reset_clear_a: assert property (disable iff (1'b0) srst |=> !pc_load && !vec_valid)
      else $error("outputs not cleared by reset");
   release_load_a: assert property ($fell(srst) |-> ##2 pc_load)
      else $error("no reset load two cycles after release");
   load_target_a: assert property (pc_load |-> pc_addr ==
      (boot_reset_select_fuse == RVA_FUSE_UNPROG ? 12'h000 : boot_reset_addr))
      else $error("wrong reset target");
   load_pulse_a: assert property (pc_load |=> !pc_load)
      else $error("reset load longer than one cycle");
   vec_addr_a: assert property (vec_valid |-> pc_addr == 12'(vec_source) + 12'h001
      + (vector_table_select ? boot_reset_addr : 12'h000)) else $error("wrong vector address");
   src_range_a: assert property (vec_valid |-> vec_source < 5'h19)
      else $error("source index out of table");
   vec_hold_a: assert property (vec_valid && !vec_ack |=> vec_valid && $stable(vec_source)
      && $stable(pc_addr)) else $error("offered vector not held");
   ack_drop_a: assert property (vec_valid && vec_ack |=> !vec_valid)
      else $error("vector not withdrawn after ack");
   load_alone_a: assert property (pc_load |-> !vec_valid)
      else $error("vector offered during reset load");
   cover property (pc_load && !boot_reset_select_fuse);
   cover property (vec_valid && vec_ack && vector_table_select);
   cover property (vec_valid && !vec_ack);
endmodule : rva_vector_gen_sva
bind rva_vector_gen rva_vector_gen_sva chk (.*);

//--- tb/rva_core_model.sv
// stand-in for the core fetch logic that takes offered vectors
// assumes vec_valid holds until acked
`timescale 1ns/10ps
module rva_core_model (
   // clock and reset
   input  wire logic clock,
   input  wire logic srst,
   // vector handshake
   input  wire logic vec_valid,
   output logic      vec_ack = 1'b0
);
   int wait_cnt = 0;
   // random stall of 0 to 3 cycles so prompt and slow takes both occur
   always @(posedge clock) begin
      if (srst || vec_valid !== 1'b1 || vec_ack) begin
         vec_ack <= 1'b0;
         wait_cnt <= $urandom_range(3, 0);
      end else if (wait_cnt == 0) vec_ack <= 1'b1;
      else wait_cnt <= wait_cnt - 1;
   end
endmodule : rva_core_model

//--- tb/reset_irq_vector_address_map_tb.sv
// self-checking bench for the vector generator
// assumes the core model acks each offered vector within a few cycles
`timescale 1ns/10ps
module reset_irq_vector_address_map_tb;
   import rva_pkg::*;
   logic clock = 1'b0, srst = 1'b1, boot_reset_select_fuse = 1'b1, vector_table_select = 1'b0;
   logic [RVA_PC_W-1:0]  boot_reset_addr = 12'h000;
   logic [24:0]          r = 25'h0;
   logic                 vec_ack, pc_load, vec_valid;
   logic [RVA_PC_W-1:0]  pc_addr;
   logic [RVA_IDX_W-1:0] vec_source;
   int                   error_cnt = 0, check_count = 0;
   always #2 clock = ~clock;
   rva_vector_gen dut (.*, .ext_irq_zero(r[0]), .ext_irq_one(r[1]),
      .pin_change_irq_group0(r[2]), .pin_change_irq_group1(r[3]), .pin_change_irq_group2(r[4]),
      .watchdog_timeout_irq(r[5]), .timer2_irq(r[8:6]), .timer1_irq(r[12:9]),
      .timer0_irq(r[15:13]), .spi_done_irq(r[16]), .rx_complete_irq(r[17]),
      .tx_buffer_empty_irq(r[18]), .tx_complete_irq(r[19]), .conversion_done_irq(r[20]),
      .nv_data_memory_ready_irq(r[21]), .comparator_irq(r[22]), .two_wire_serial_irq(r[23]),
      .self_program_store_ready_irq(r[24]));
   rva_core_model core (.clock(clock), .srst(srst), .vec_valid(vec_valid), .vec_ack(vec_ack));
   // expected vector: table address n+1, moved by base when relocated
   function automatic logic [11:0] vec_addr(input logic sel, input logic [11:0] b, input int i);
      return (sel ? b : 12'h000) + 12'(i + 1);
   endfunction : vec_addr
   // expected reset target from the fuse encoding
   function automatic logic [11:0] rst_addr(input logic fuse, input logic [11:0] b);
      return (fuse == RVA_FUSE_UNPROG) ? RVA_RESET_ADDR : b;
   endfunction : rst_addr
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic finish_test();
      if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   // config only changes under reset, before any request is raised
   task automatic restart(input logic fuse, input logic sel);
      int n;
      @(posedge clock);
      srst <= 1'b1;
      boot_reset_select_fuse <= fuse;
      vector_table_select <= sel;
      // default boot section while the table stays low, random otherwise
      boot_reset_addr <= sel ? 12'($urandom) : RVA_BOOT_DFLT;
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      n = 0;
      do begin @(posedge clock); #1; n++; end while (pc_load !== 1'b1 && n < 10);
      chk("reset load", 12'h001, 12'(pc_load));
      chk("reset target", rst_addr(fuse, boot_reset_addr), pc_addr);
   endtask : restart
   // request dropped on the ack edge, as the core clears the flag
   task automatic offer(input logic [24:0] req);
      int n, i;
      i = 0;
      while (!req[i]) i++;
      @(posedge clock) r <= req;
      n = 0;
      do begin @(posedge clock); #1; n++; end while (vec_valid !== 1'b1 && n < 10);
      chk("vector valid", 12'h001, 12'(vec_valid));
      chk("vector", vec_addr(vector_table_select, boot_reset_addr, i), pc_addr);
      chk("source", 12'(i), 12'(vec_source));
      while (vec_ack !== 1'b1 && n < 20) begin @(posedge clock); #1; n++; end
      @(posedge clock) r <= '0;
   endtask : offer
   initial begin
      void'($urandom(31072));
      for (int m = 0; m < 4; m++) begin
         restart(m[1], m[0]);
         for (int i = 0; i < 25; i++) offer(25'h1 << i);
         offer(25'h1ffffff);
         offer(25'h1800000);
         repeat (8) offer(25'($urandom) | 25'h1000000);
      end
      finish_test();
   end
   // cut a hang well past the expected run length
   initial begin
      #40000;
      error_cnt++;
      finish_test();
   end
endmodule : reset_irq_vector_address_map_tb
